// *** common/aic_pkg.sv ***
/*
 package for the analog input configuration bank: word addresses,
 field values, reset values and carrier structs.
 assumes a host that issues one word-addressed access at a time.
*/
// Operation
// - per-channel 16-bit resolution index, 0..12
// - global index writes all, reads common or mixed
// - stream uses only its own index
// - index zero selects variant default; stream index 0 stays 0
// - legal range per variant; 9+ high-res
// - write mask blocks line config writes
// - line function bit: 1 analog
// - analog to digital forces input direction
// - bit equals channel; 0-3 stay analog
// - non-stream analog read sets flexible line analog
// - per-channel negative selector, 199 single
// - global negative: 1, 199, mixed
// - differential uses positive channel settings
// - channels 14, 15 always single-ended
// - voltage read, channel 1 at 2
// - read-only float voltages from address 0
// - 16-bit step one, float step two
package aic_pkg;
  // =========================================
  // word addresses
  localparam logic [15:0] ADDR_VOLT = 16'h0000;
  localparam logic [15:0] ADDR_FUNC = 16'h0b40;
  localparam logic [15:0] ADDR_MASK = 16'h0b54;
  localparam logic [15:0] ADDR_SRES = 16'h0faa;
  localparam logic [15:0] ADDR_NEG = 16'ha028;
  localparam logic [15:0] ADDR_RES = 16'ha21c;
  localparam logic [15:0] ADDR_GNEG = 16'hab7e;
  localparam logic [15:0] ADDR_GRES = 16'hab7f;
  localparam logic [15:0] STEP_U16 = 16'h0001;
  localparam logic [15:0] STEP_F32 = 16'h0002;
  // =========================================
  // field values
  localparam int NUM_CH = 14;
  localparam logic [15:0] NEG_SINGLE = 16'h00c7;
  localparam logic [15:0] NEG_DIFF = 16'h0001;
  localparam logic [15:0] MIXED = 16'hffff;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [3:0] HIRES_MIN = 4'h9;
  localparam logic [3:0] LAST_BUILTIN = 4'hd;
  localparam logic [31:0] FIXED_MASK = 32'h0000000f;
  localparam logic [31:0] FLEX_MASK = 32'h00000ff0;
  localparam logic [31:0] FUNC_RST = 32'h00000fff;
  localparam logic [31:0] WMASK_RST = 32'h00000000;
  localparam logic [3:0] FLEX_LO = 4'h4;
  localparam logic [3:0] FLEX_HI = 4'hb;
  // =========================================
  // carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [31:0] wdata;
  } aic_reg_req_t;
  typedef struct packed {
    logic [3:0] chan;
    logic [3:0] res_index;
    logic diff;
    logic [7:0] neg;
    logic hires;
    logic stream;
  } aic_conv_t;
endpackage

// *** rtl/aic_conv_sel.sv ***
/*
 conversion setting selector: turns a conversion request into the
 registered settings for the converter.
 assumes the caller has already looked up the positive channel's
 stored index and negative selector on the same clock.
*/
`timescale 1ns/1ps
module aic_conv_sel
  import aic_pkg::*;
#(
  parameter logic [3:0] RES_DEFAULT = 4'h9
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // request
  input wire logic i_req,
  input wire logic i_stream,
  input wire logic [3:0] i_chan,
  input wire logic [15:0] i_res,
  input wire logic [15:0] i_neg,
  input wire logic [31:0] i_stream_idx,
  // settings out
  output aic_conv_t o_conv,
  output logic o_go
);
  // =========================================
  // combinational selection
  aic_conv_t next_conv;
  always_comb
  begin
    next_conv.chan = i_chan;
    next_conv.stream = i_stream;
    if (i_stream)
      next_conv.res_index = i_stream_idx[3:0];
    else if (i_res == RES_RST)
      next_conv.res_index = RES_DEFAULT;
    else
      next_conv.res_index = i_res[3:0];
    next_conv.hires = next_conv.res_index >= HIRES_MIN;
    // temperature and ground never pair up
    next_conv.diff = (i_chan <= LAST_BUILTIN) &&
                     (i_neg != NEG_SINGLE);
    next_conv.neg = next_conv.diff ? i_neg[7:0] : NEG_SINGLE[7:0];
  end
  // =========================================
  // output registers
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_conv <= '0;
      o_go <= 1'b0;
    end
    else
    begin
      o_go <= i_req;
      if (i_req)
        o_conv <= next_conv;
    end
  end
  // =========================================
  // checks
  default_idx_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) i_req && !i_stream && i_res == RES_RST
    |=> o_go && o_conv.res_index == RES_DEFAULT)
    else $error("zero index did not select default");
  temp_single_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) i_req && i_chan > LAST_BUILTIN
    |=> !o_conv.diff)
    else $error("channel 14 or 15 converted differentially");
  stream_idx_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) i_req && i_stream
    |=> o_conv.res_index == $past(i_stream_idx[3:0]))
    else $error("stream conversion ignored stream index");
  hires_sel_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) i_req && !i_stream && i_res > 16'h0008
    |=> o_conv.hires)
    else $error("high index not routed to sigma-delta");
endmodule

// *** rtl/aic_regs.sv ***
/*
 analog input configuration register bank: resolution indexes,
 line function and write mask, negative selectors, voltage readback.
 assumes voltages arrive from the converter on this clock and that
 the host waits for ack before its next access.
*/
`timescale 1ns/1ps
module aic_regs
  import aic_pkg::*;
#(
  parameter logic [15:0] RES_MAX = 16'h000c,
  parameter logic [3:0] RES_DEFAULT = 4'h9
) (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // register access
  input wire aic_reg_req_t i_reg,
  output logic [31:0] o_reg_rdata,
  output logic o_reg_ack,
  output logic o_reg_err,
  // converter voltages, channel 0 in the low word
  input wire logic [NUM_CH*32-1:0] i_voltage,
  // conversion request
  input wire logic i_conv_req,
  input wire logic i_conv_stream,
  input wire logic [3:0] i_conv_chan,
  // conversion settings
  output aic_conv_t o_conv,
  output logic o_conv_go,
  // line configuration
  output logic [31:0] o_line_function,
  output logic [31:0] o_line_write_mask,
  output logic [31:0] o_dir_to_input
);
  // =========================================
  // helpers
  // channel slot of a register array, or no hit
  function automatic logic in_array(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] step
  );
    logic [15:0] off;
    off = addr - base;
    in_array = (addr >= base) && (off < step * 16'(NUM_CH)) &&
               ((step == STEP_U16) || !off[0]);
  endfunction
  function automatic logic [3:0] chan_of(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] step
  );
    logic [15:0] off;
    off = addr - base;
    chan_of = (step == STEP_F32) ? off[4:1] : off[3:0];
  endfunction
  // =========================================
  // storage
  logic [15:0] res_idx [NUM_CH]; // per-channel index
  logic [15:0] neg_sel [NUM_CH]; // per-channel negative
  logic [31:0] stream_idx; // stream-only index
  logic [31:0] func; // line function bits
  logic [31:0] wmask; // line write mask
  logic [31:0] next_func;
  logic [31:0] next_wmask;
  // =========================================
  // access decode
  logic wr;
  logic rd;
  logic [15:0] wval;
  logic res_ok;
  logic hit_volt;
  logic hit_res;
  logic hit_neg;
  logic [3:0] ch_volt;
  logic [3:0] ch_res;
  logic [3:0] ch_neg;
  assign wr = i_reg.wr;
  assign rd = i_reg.rd;
  assign wval = i_reg.wdata[15:0];
  assign res_ok = (i_reg.wdata <= 32'(RES_MAX));
  assign hit_volt = in_array(i_reg.addr, ADDR_VOLT, STEP_F32);
  assign hit_res = in_array(i_reg.addr, ADDR_RES, STEP_U16);
  assign hit_neg = in_array(i_reg.addr, ADDR_NEG, STEP_U16);
  // float voltages step two words, 16-bit registers one
  assign ch_volt = chan_of(i_reg.addr, ADDR_VOLT, STEP_F32);
  assign ch_res = chan_of(i_reg.addr, ADDR_RES, STEP_U16);
  assign ch_neg = chan_of(i_reg.addr, ADDR_NEG, STEP_U16);
  // =========================================
  // resolution indexes
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        res_idx[i] <= RES_RST;
    end
    else if (wr && res_ok)
    begin
      if (i_reg.addr == ADDR_GRES)
      begin
        // global write fans out to every channel
        for (int i = 0; i < NUM_CH; i++)
          res_idx[i] <= wval;
      end
      else if (hit_res)
        res_idx[ch_res] <= wval;
    end
  end
  // stream index is kept apart from the others
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      stream_idx <= 32'(RES_RST);
    else if (wr && res_ok && i_reg.addr == ADDR_SRES)
      stream_idx <= i_reg.wdata;
  end
  // =========================================
  // negative selectors
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      for (int i = 0; i < NUM_CH; i++)
        neg_sel[i] <= NEG_SINGLE;
    end
    else if (wr && i_reg.addr == ADDR_GNEG)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        // differential pairs even with next odd
        if (wval == NEG_DIFF && i % 2 == 0)
          neg_sel[i] <= 16'(i + 1);
        else if (wval == NEG_SINGLE)
          neg_sel[i] <= NEG_SINGLE;
      end
    end
    else if (wr && hit_neg)
      neg_sel[ch_neg] <= wval;
  end
  // =========================================
  // line function and write mask
  logic auto_analog;
  assign auto_analog = i_conv_req && !i_conv_stream &&
                       i_conv_chan >= FLEX_LO &&
                       i_conv_chan <= FLEX_HI;
  always_comb
  begin
    next_wmask = wmask;
    next_func = func;
    if (wr && i_reg.addr == ADDR_MASK)
      next_wmask = i_reg.wdata & FLEX_MASK;
    if (wr && i_reg.addr == ADDR_FUNC)
    begin
      // masked lines keep their old setting
      next_func = (func & wmask) |
                  (i_reg.wdata & ~wmask);
    end
    // a non-stream analog read claims its flexible line
    if (auto_analog)
      next_func[i_conv_chan] = 1'b1;
    // dedicated inputs never leave analog mode
    next_func = (next_func & FLEX_MASK) | FIXED_MASK;
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      func <= FUNC_RST;
      wmask <= WMASK_RST;
      o_dir_to_input <= '0;
    end
    else
    begin
      func <= next_func;
      wmask <= next_wmask;
      // pulse per line leaving analog mode
      o_dir_to_input <= func & ~next_func;
    end
  end
  assign o_line_function = func;
  assign o_line_write_mask = wmask;
  // =========================================
  // summaries for the global registers
  logic res_same;
  logic neg_all_single;
  logic neg_all_diff;
  always_comb
  begin
    res_same = 1'b1;
    neg_all_single = 1'b1;
    neg_all_diff = 1'b1;
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (res_idx[i] != res_idx[0])
        res_same = 1'b0;
      if (neg_sel[i] != NEG_SINGLE)
        neg_all_single = 1'b0;
      if (i % 2 == 0 && neg_sel[i] == NEG_SINGLE)
        neg_all_diff = 1'b0;
    end
  end
  // =========================================
  // read data and status
  logic [31:0] next_rdata;
  logic next_err;
  always_comb
  begin
    next_rdata = '0;
    next_err = 1'b0;
    if (hit_volt)
    begin
      // voltages are read-only floats
      next_rdata = i_voltage[32*ch_volt +: 32];
      next_err = wr;
    end
    else if (hit_res)
    begin
      next_rdata = {16'h0000, res_idx[ch_res]};
      next_err = wr && !res_ok;
    end
    else if (hit_neg)
      next_rdata = {16'h0000, neg_sel[ch_neg]};
    else
    begin
      case (i_reg.addr)
        ADDR_GRES:
        begin
          next_rdata = {16'h0000,
                        res_same ? res_idx[0] : MIXED};
          next_err = wr && !res_ok;
        end
        ADDR_GNEG:
        begin
          if (neg_all_single)
            next_rdata = {16'h0000, NEG_SINGLE};
          else if (neg_all_diff)
            next_rdata = {16'h0000, NEG_DIFF};
          else
            next_rdata = {16'h0000, MIXED};
          next_err = wr && wval != NEG_DIFF &&
                     wval != NEG_SINGLE;
        end
        ADDR_SRES:
        begin
          next_rdata = stream_idx;
          next_err = wr && !res_ok;
        end
        ADDR_FUNC: next_rdata = func;
        ADDR_MASK: next_rdata = wmask;
        default: next_err = 1'b1; // unmapped
      endcase
    end
  end
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_reg_rdata <= '0;
      o_reg_ack <= 1'b0;
      o_reg_err <= 1'b0;
    end
    else
    begin
      o_reg_ack <= wr || rd;
      o_reg_err <= (wr || rd) && next_err;
      if (rd)
        o_reg_rdata <= next_rdata;
    end
  end
  // =========================================
  // conversion settings
  logic [15:0] conv_res;
  logic [15:0] conv_neg;
  // only the positive channel's settings matter
  assign conv_res = (i_conv_chan <= LAST_BUILTIN) ?
                    res_idx[i_conv_chan] : RES_RST;
  assign conv_neg = (i_conv_chan <= LAST_BUILTIN) ?
                    neg_sel[i_conv_chan] : NEG_SINGLE;
  aic_conv_sel #(
    .RES_DEFAULT(RES_DEFAULT)
  ) u_conv_sel (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_req(i_conv_req),
    .i_stream(i_conv_stream),
    .i_chan(i_conv_chan),
    .i_res(conv_res),
    .i_neg(conv_neg),
    .i_stream_idx(stream_idx),
    .o_conv(o_conv),
    .o_go(o_conv_go)
  );
  // =========================================
  // checks
  sequence s_gres_wr;
    wr && i_reg.addr == ADDR_GRES && res_ok;
  endsequence
  sequence s_gres_rd;
    rd && i_reg.addr == ADDR_GRES;
  endsequence
  global_res_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) s_gres_wr ##1 s_gres_rd
    |=> o_reg_rdata == {16'h0000, $past(i_reg.wdata[15:0], 2)})
    else $error("global index readback wrong after write");
  // same check when the host idles one cycle in between
  global_gap_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) s_gres_wr ##1 !wr ##1 s_gres_rd
    |=> o_reg_rdata == {16'h0000, $past(i_reg.wdata[15:0], 3)})
    else $error("global index readback wrong after idle cycle");
  res_reject_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) wr && hit_res && !res_ok
    |=> res_idx[$past(ch_res)] == $past(res_idx[ch_res]) && o_reg_err)
    else $error("over-range index was stored");
  stream_apart_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) wr && (hit_res || i_reg.addr == ADDR_GRES)
    |=> $stable(stream_idx))
    else $error("stream index moved on channel index write");
  mask_hold_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) wr && i_reg.addr == ADDR_FUNC && !auto_analog
    |=> ((func ^ $past(func)) & $past(wmask)) == '0)
    else $error("masked line function changed");
  fixed_lines_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) func[3:0] == 4'hf)
    else $error("dedicated input left analog mode");
  dir_force_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) ##1 o_dir_to_input == ($past(func) & ~func))
    else $error("direction force mismatch on analog exit");
  auto_analog_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) auto_analog |=> func[$past(i_conv_chan)])
    else $error("analog read did not claim its line");
  reset_neg_a: assert property (@(posedge i_sys_clk)
    !i_nrst |=> neg_sel[0] == NEG_SINGLE && res_idx[13] == RES_RST
    && wmask == '0)
    else $error("reset values wrong");
  volt_read_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) rd && i_reg.addr == ADDR_VOLT + STEP_F32
    |=> o_reg_rdata == $past(i_voltage[63:32]))
    else $error("channel 1 voltage not at word 2");
  // a global single-ended write leaves no pair behind
  gneg_single_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) wr && i_reg.addr == ADDR_GNEG &&
    wval == NEG_SINGLE |=> neg_all_single)
    else $error("global single-ended write left a pair");
  gneg_diff_a: assert property (@(posedge i_sys_clk)
    disable iff (!i_nrst) wr && i_reg.addr == ADDR_GNEG &&
    wval == NEG_DIFF |=> neg_all_diff)
    else $error("global differential write missed a channel");
endmodule

// *** verification/aic_volt_model.sv ***
/*
 converter voltage model: a fixed, distinct word for each channel.
 assumes the bank samples these words on its own clock.
*/
`timescale 1ns/1ps
module aic_volt_model
  import aic_pkg::*;
(
  // voltages, channel 0 in the low word
  output logic [NUM_CH*32-1:0] o_voltage
);
  // ========================================
  // pattern
  // each channel gets its own value, so a misplaced read shows up
  always_comb
  begin
    for (int n = 0; n < NUM_CH; n++)
    begin
      o_voltage[n*32 +: 32] = 32'h40a00000 + 32'(n);
    end
  end
endmodule

// *** verification/test_aic_regs.sv ***
/*
 testbench for the analog input configuration bank.
 assumes the default parameters (max index 12, default index 9).
*/
`timescale 1ns/1ps
module test_aic_regs
  import aic_pkg::*;
;
  // ========================================
  // signals
  logic i_sys_clk = 1'b0;
  logic i_nrst = 1'b0;
  aic_reg_req_t i_reg = '0;
  logic i_conv_req = 1'b0;
  logic i_conv_stream = 1'b0;
  logic [3:0] i_conv_chan = 4'h0;
  logic [NUM_CH*32-1:0] volt;
  logic [31:0] o_reg_rdata;
  logic [31:0] o_line_function;
  logic [31:0] o_line_write_mask;
  logic [31:0] o_dir_to_input;
  logic o_reg_ack;
  logic o_reg_err;
  logic o_conv_go;
  aic_conv_t o_conv;
  logic [31:0] rd; // last read data
  logic [31:0] seen; // dir pulses at end of last access
  int bad_count = 0;
  int compares = 0;
  // clock, 40 ns period
  always #20 i_sys_clk = ~i_sys_clk;
  aic_volt_model model (.o_voltage(volt));
  aic_regs #(.RES_MAX(16'h000c), .RES_DEFAULT(4'h9)) dut (
    .i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_reg(i_reg),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack),
    .o_reg_err(o_reg_err), .i_voltage(volt), .i_conv_req(i_conv_req),
    .i_conv_stream(i_conv_stream), .i_conv_chan(i_conv_chan),
    .o_conv(o_conv), .o_conv_go(o_conv_go),
    .o_line_function(o_line_function),
    .o_line_write_mask(o_line_write_mask),
    .o_dir_to_input(o_dir_to_input));
  // ========================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one access; e is the expected error flag
  task automatic acc(input logic w, input logic [15:0] a,
    input logic [31:0] d, input logic e);
    @(posedge i_sys_clk);
    #1;
    i_reg = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge i_sys_clk);
    #1;
    i_reg = '0;
    rd = o_reg_rdata;
    seen = o_dir_to_input;
    chk({30'h0, o_reg_ack, o_reg_err}, {30'h0, 1'b1, e});
  endtask
  task automatic rdm(input logic [15:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask
  // conversion request and expected settings
  task automatic cvx(input logic s, input logic [3:0] c,
    input logic [3:0] r, input logic df, input logic [7:0] ng);
    aic_conv_t exp;
    exp = '{chan: c, res_index: r, diff: df, neg: ng,
      hires: (r >= 4'h9), stream: s};
    @(posedge i_sys_clk);
    #1;
    i_conv_req = 1'b1;
    i_conv_stream = s;
    i_conv_chan = c;
    @(posedge i_sys_clk);
    #1;
    i_conv_req = 1'b0;
    chk({31'h0, o_conv_go}, 32'h1);
    chk(32'(o_conv), 32'(exp));
  endtask
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ========================================
  // watchdog
  initial
  begin
    #200000;
    bad_count++;
    summarize();
  end
  // ========================================
  // tests
  initial
  begin
    repeat (10) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    // reset values and voltage map
    for (int n = 0; n < NUM_CH; n++)
    begin
      rdm(ADDR_NEG + 16'(n), 32'hc7);
      rdm(ADDR_RES + 16'(n), 32'h0);
      rdm(16'(2*n), 32'h40a00000 + 32'(n));
    end
    rdm(16'h0002, 32'h40a00001);
    rdm(ADDR_GNEG, 32'hc7);
    rdm(ADDR_FUNC, 32'hfff);
    rdm(ADDR_MASK, 32'h0);
    acc(1'b1, 16'h0002, 32'h1, 1'b1);
    acc(1'b0, 16'h0003, 32'h0, 1'b1);
    chk(rd, 32'h0);
    acc(1'b0, 16'h1234, 32'h0, 1'b1);
    chk(rd, 32'h0);
    // per-channel indexes, full legal range
    for (int n = 0; n < NUM_CH; n++)
      acc(1'b1, ADDR_RES + 16'(n), 32'(n % 13), 1'b0);
    for (int n = 0; n < NUM_CH; n++)
      rdm(ADDR_RES + 16'(n), 32'(n % 13));
    acc(1'b1, ADDR_RES + 16'h3, 32'hd, 1'b1);
    rdm(ADDR_RES + 16'h3, 32'h3);
    rdm(ADDR_GRES, 32'hffff);
    cvx(1'b0, 4'h3, 4'h3, 1'b0, 8'hc7);
    cvx(1'b0, 4'ha, 4'ha, 1'b0, 8'hc7);
    cvx(1'b0, 4'h0, 4'h9, 1'b0, 8'hc7);
    // stream index stands apart
    acc(1'b1, ADDR_SRES, 32'h6, 1'b0);
    rdm(ADDR_SRES, 32'h6);
    cvx(1'b1, 4'ha, 4'h6, 1'b0, 8'hc7);
    acc(1'b1, ADDR_SRES, 32'hd, 1'b1);
    rdm(ADDR_SRES, 32'h6);
    // global index
    acc(1'b1, ADDR_GRES, 32'h7, 1'b0);
    rdm(ADDR_GRES, 32'h7);
    for (int n = 0; n < NUM_CH; n++)
      rdm(ADDR_RES + 16'(n), 32'h7);
    rdm(ADDR_GRES, 32'h7);
    acc(1'b1, ADDR_GRES, 32'hd, 1'b1);
    rdm(ADDR_GRES, 32'h7);
    cvx(1'b1, 4'h2, 4'h6, 1'b0, 8'hc7);
    // negative selectors, pairs and fixed channels
    acc(1'b1, ADDR_GNEG, 32'h1, 1'b0);
    rdm(ADDR_GNEG, 32'h1);
    rdm(ADDR_NEG + 16'h2, 32'h3);
    cvx(1'b0, 4'h2, 4'h7, 1'b1, 8'h03);
    cvx(1'b0, 4'he, 4'h9, 1'b0, 8'hc7);
    cvx(1'b0, 4'hf, 4'h9, 1'b0, 8'hc7);
    acc(1'b1, ADDR_NEG + 16'h4, 32'hc7, 1'b0);
    rdm(ADDR_GNEG, 32'hffff);
    acc(1'b1, ADDR_GNEG, 32'h5, 1'b1);
    acc(1'b1, ADDR_GNEG, 32'hc7, 1'b0);
    rdm(ADDR_GNEG, 32'hc7);
    // line function under the write mask
    acc(1'b1, ADDR_MASK, 32'h30, 1'b0);
    acc(1'b1, ADDR_FUNC, 32'h0, 1'b0);
    chk(seen, 32'hfc0);
    @(posedge i_sys_clk);
    #1;
    chk(o_dir_to_input, 32'h0);
    rdm(ADDR_FUNC, 32'h3f);
    chk(o_line_function, 32'h3f);
    acc(1'b1, ADDR_MASK, 32'hffffffff, 1'b0);
    rdm(ADDR_MASK, 32'hff0);
    chk(o_line_write_mask, 32'hff0);
    acc(1'b1, ADDR_FUNC, 32'hffffffff, 1'b0);
    rdm(ADDR_FUNC, 32'h3f);
    acc(1'b1, ADDR_MASK, 32'h0, 1'b0);
    cvx(1'b0, 4'h6, 4'h7, 1'b0, 8'hc7);
    rdm(ADDR_FUNC, 32'h7f);
    acc(1'b1, ADDR_FUNC, 32'hffffffff, 1'b0);
    rdm(ADDR_FUNC, 32'hfff);
    // second reset in mid-run
    @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b0;
    repeat (2) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    rdm(ADDR_RES + 16'h5, 32'h0);
    rdm(ADDR_SRES, 32'h0);
    summarize();
  end
endmodule
